/* File: smc_params.svh */
// Constants for the supply monitor control block
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// Register indices, byte address is four times the index
`define SMC_IDX_DET_CTRL       4'h0
`define SMC_IDX_DET_LEVEL      4'h1
`define SMC_IDX_WARN_CTRL      4'h8
`define SMC_IDX_WARN_IRQ_CTRL  4'h9
`define SMC_IDX_WARN_FLAGS     4'ha
`define SMC_IDX_WARN_STATUS    4'hb

// Field positions
`define SMC_POS_SAMPLE_RATE    4
`define SMC_POS_RUN_MODE       2
`define SMC_POS_SLEEP_MODE     0
`define SMC_POS_LEVEL          0
`define SMC_POS_OFFSET         0
`define SMC_POS_DIRECTION      1
`define SMC_POS_IRQ_ENABLE     0
`define SMC_POS_IRQ_FLAG       0
`define SMC_POS_BELOW_STATUS   0

// Reset values of register fields not loaded from fuses
`define SMC_RST_OFFSET         2'h0
`define SMC_RST_DIRECTION      2'h0
`define SMC_RST_IRQ_ENABLE     1'h0
`define SMC_RST_IRQ_FLAG       1'h0
`define SMC_RST_BELOW_STATUS   1'h0

// Timing
`define SMC_CLK_HZ             50000000
`define SMC_SAMPLE_FAST_HZ     1000
`define SMC_SAMPLE_SLOW_HZ     125
`define SMC_SAMPLE_CYC_FAST    (`SMC_CLK_HZ / `SMC_SAMPLE_FAST_HZ)
`define SMC_SAMPLE_CYC_SLOW    (`SMC_CLK_HZ / `SMC_SAMPLE_SLOW_HZ)
`define SMC_SAMPLE_CNT_W       19
`define SMC_UNLOCK_WINDOW      3'h4

`endif

/* File: smc_pkg.sv */
// Types for the supply monitor control block
package smc_pkg;
	`include "smc_params.svh"

	typedef enum logic [1:0] {
		SMC_MODE_DIS  = 2'h0,
		SMC_MODE_CONT = 2'h1,
		SMC_MODE_SAMP = 2'h2,
		SMC_MODE_HOLD = 2'h3
	} smc_mode_t;

	typedef enum logic [1:0] {
		SMC_DIR_BELOW = 2'h0,
		SMC_DIR_ABOVE = 2'h1,
		SMC_DIR_CROSS = 2'h2,
		SMC_DIR_RSVD  = 2'h3
	} smc_dir_t;

	typedef enum logic [1:0] {
		SMC_ST_LOAD = 2'b01,
		SMC_ST_RUN  = 2'b10
	} smc_fsm_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} smc_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} smc_wb_rsp_t;

	typedef struct packed {
		logic       sample_rate;
		logic [1:0] run_mode;
		logic [1:0] sleep_mode;
		logic [2:0] level;
	} smc_fuse_t;

	typedef struct packed {
		logic f1;
		logic f2;
		logic f3;
		logic lvl;
	} smc_sync_st_t;

	typedef struct packed {
		logic [`SMC_SAMPLE_CNT_W-1:0] cnt;
		logic                         tick;
	} smc_smp_st_t;

	typedef struct packed {
		smc_fsm_t   fsm;
		logic       sample_rate;
		smc_mode_t  run_mode;
		smc_mode_t  sleep_mode;
		logic [2:0] level;
		logic [1:0] offset;
		smc_dir_t   direction;
		logic       irq_en;
		logic       irq_flag;
		logic       below;
		logic       prev_below;
		logic       seen;
		logic [2:0] unlock_cnt;
		logic       ack;
		logic [7:0] rdata;
		logic       irq;
		logic       det_en;
		logic       det_sampled;
		logic       exec_hold;
	} smc_top_st_t;
endpackage : smc_pkg

/* File: smc_sampler.sv */
// Sample tick generator for sampled detector mode
`timescale 1ns/1ps
`default_nettype none
module smc_sampler
	import smc_pkg::*;
#(
	parameter int P_CYC_FAST = `SMC_SAMPLE_CYC_FAST,
	parameter int P_CYC_SLOW = `SMC_SAMPLE_CYC_SLOW
) (
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_run,
	input  wire logic i_slow,
	output logic      o_tick
);
	localparam logic [`SMC_SAMPLE_CNT_W-1:0] LAST_FAST =
		`SMC_SAMPLE_CNT_W'(P_CYC_FAST - 1);
	localparam logic [`SMC_SAMPLE_CNT_W-1:0] LAST_SLOW =
		`SMC_SAMPLE_CNT_W'(P_CYC_SLOW - 1);

	smc_smp_st_t st_ff;
	smc_smp_st_t nxt_st;
	logic [`SMC_SAMPLE_CNT_W-1:0] last;

	always_comb begin
		last        = i_slow ? LAST_SLOW : LAST_FAST;
		nxt_st      = st_ff;
		nxt_st.tick = 1'b0;
		if (!i_run) begin
			nxt_st.cnt = '0;
		end else if (st_ff.cnt >= last) begin
			nxt_st.cnt  = '0;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + `SMC_SAMPLE_CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_tick = st_ff.tick;
endmodule : smc_sampler
`default_nettype wire

/* File: smc_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module smc_sync
	import smc_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_async,
	output logic      o_level
);
	smc_sync_st_t st_ff;
	smc_sync_st_t nxt_st;

	always_comb begin
		nxt_st     = st_ff;
		nxt_st.f1  = i_async;
		nxt_st.f2  = st_ff.f1;
		nxt_st.f3  = st_ff.f2;
		// Accept a change once stages two and three agree
		if (st_ff.f2 == st_ff.f3) begin
			nxt_st.lvl = st_ff.f3;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_level = st_ff.lvl;
endmodule : smc_sync
`default_nettype wire

/* File: smc_top.sv */
// Supply monitor control: registers, mode select and warning logic
`timescale 1ns/1ps
`default_nettype none
module smc_top
	import smc_pkg::*;
#(
	parameter int P_CYC_FAST = `SMC_SAMPLE_CYC_FAST,
	parameter int P_CYC_SLOW = `SMC_SAMPLE_CYC_SLOW
) (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire smc_wb_req_t i_wb,
	output smc_wb_rsp_t      o_wb,
	input  wire smc_fuse_t   i_fuse,
	input  wire logic        i_unlock,
	input  wire logic        i_deep_sleep,
	input  wire logic        i_warn_below,
	input  wire logic        i_det_ready,
	output logic             o_det_enable,
	output logic             o_det_sampled,
	output logic             o_sample_strobe,
	output logic [2:0]       o_det_threshold,
	output logic [1:0]       o_warn_offset,
	output logic             o_exec_hold,
	output logic             o_warn_irq
);
	smc_top_st_t st_ff;
	smc_top_st_t nxt_st;

	logic        below_sync;
	logic        ready_sync;
	logic        tick;
	logic        tick_ff;
	logic        req;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [3:0]  idx;
	logic [7:0]  wbyte;
	smc_mode_t   mode;
	logic        enabled;
	logic        sampled;
	logic        evaluate;
	logic        fall;
	logic        rise;
	logic        trigger;
	logic        flag_set;
	logic        flag_clr;
	logic [7:0]  rd_mux;
	logic [15:0] hit;
	logic        unlocked;
	logic        wr_live;
	logic        wr_flags;
	logic        sleep_ff;

	// Comparator outputs come from the analog side
	smc_sync u_below_sync (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_async (i_warn_below),
		.o_level (below_sync)
	);

	smc_sync u_ready_sync (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_async (i_det_ready),
		.o_level (ready_sync)
	);

	smc_sampler #(
		.P_CYC_FAST (P_CYC_FAST),
		.P_CYC_SLOW (P_CYC_SLOW)
	) u_sampler (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.i_run  (sampled),
		.i_slow (st_ff.sample_rate),
		.o_tick (tick)
	);

	// Bus decode
	always_comb begin
		req    = i_wb.cyc & i_wb.stb & ~st_ff.ack;
		wr     = req & i_wb.we & i_wb.sel[0];
		rd     = req & ~i_wb.we;
		idx    = i_wb.adr[5:2];
		wbyte  = i_wb.dat[7:0];
		mapped = (i_wb.adr[7:6] == 2'h0) && (i_wb.adr[1:0] == 2'h0);
	end

	// One select line per register index
	for (genvar g = 0; g < 16; g++) begin : g_hit
		assign hit[g] = mapped & (idx == 4'(g));
	end

	// Write qualifiers
	always_comb begin
		wr_live  = wr & mapped & (st_ff.fsm == SMC_ST_RUN);
		wr_flags = wr & hit[`SMC_IDX_WARN_FLAGS];
		unlocked = st_ff.unlock_cnt != 3'h0;
	end

	// Effective detector mode
	always_comb begin
		if (st_ff.fsm != SMC_ST_RUN) begin
			mode = SMC_MODE_DIS;
		end else if (i_deep_sleep) begin
			mode = st_ff.sleep_mode;
		end else begin
			mode = st_ff.run_mode;
		end
		case (mode)
			SMC_MODE_DIS: begin
				enabled = 1'b0;
				sampled = 1'b0;
			end
			SMC_MODE_CONT: begin
				enabled = 1'b1;
				sampled = 1'b0;
			end
			SMC_MODE_SAMP: begin
				enabled = 1'b1;
				sampled = 1'b1;
			end
			SMC_MODE_HOLD: begin
				// Reserved in deep sleep, treated as off
				enabled = ~i_deep_sleep;
				sampled = 1'b0;
			end
			default: begin
				enabled = 1'b0;
				sampled = 1'b0;
			end
		endcase
		evaluate = enabled & (~sampled | tick);
	end

	// Warning trigger detection
	always_comb begin
		fall = ~st_ff.prev_below & below_sync;
		rise = st_ff.prev_below & ~below_sync;
		case (st_ff.direction)
			SMC_DIR_BELOW: trigger = fall;
			SMC_DIR_ABOVE: trigger = rise;
			SMC_DIR_CROSS: trigger = fall | rise;
			SMC_DIR_RSVD:  trigger = 1'b0;
			default:       trigger = 1'b0;
		endcase
		// First evaluation only seeds the previous level
		flag_set = evaluate & st_ff.seen & trigger;
		flag_clr = wr_flags & wbyte[`SMC_POS_IRQ_FLAG];
	end

	// Read data
	always_comb begin
		rd_mux = 8'h00;
		case (idx)
			`SMC_IDX_DET_CTRL: begin
				rd_mux[`SMC_POS_SAMPLE_RATE]       = st_ff.sample_rate;
				rd_mux[`SMC_POS_RUN_MODE +: 2]     = st_ff.run_mode;
				rd_mux[`SMC_POS_SLEEP_MODE +: 2]   = st_ff.sleep_mode;
			end
			`SMC_IDX_DET_LEVEL: begin
				rd_mux[`SMC_POS_LEVEL +: 3] = st_ff.level;
			end
			`SMC_IDX_WARN_CTRL: begin
				rd_mux[`SMC_POS_OFFSET +: 2] = st_ff.offset;
			end
			`SMC_IDX_WARN_IRQ_CTRL: begin
				rd_mux[`SMC_POS_DIRECTION +: 2] = st_ff.direction;
				rd_mux[`SMC_POS_IRQ_ENABLE]     = st_ff.irq_en;
			end
			`SMC_IDX_WARN_FLAGS: begin
				rd_mux[`SMC_POS_IRQ_FLAG] = st_ff.irq_flag;
			end
			`SMC_IDX_WARN_STATUS: begin
				rd_mux[`SMC_POS_BELOW_STATUS] = st_ff.below;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
		if (!mapped) begin
			rd_mux = 8'h00;
		end
	end

	// Next state
	always_comb begin
		nxt_st     = st_ff;
		nxt_st.ack = req;
		if (rd) begin
			nxt_st.rdata = rd_mux;
		end

		// Fuse load once after reset release
		case (st_ff.fsm)
			SMC_ST_LOAD: begin
				nxt_st.sample_rate = i_fuse.sample_rate;
				nxt_st.run_mode    = smc_mode_t'(i_fuse.run_mode);
				nxt_st.sleep_mode  = smc_mode_t'(i_fuse.sleep_mode);
				nxt_st.level       = i_fuse.level;
				nxt_st.fsm         = SMC_ST_RUN;
			end
			SMC_ST_RUN: begin
				nxt_st.fsm = SMC_ST_RUN;
			end
			default: begin
				nxt_st.fsm = SMC_ST_LOAD;
			end
		endcase

		// Unlock window, counted in clock cycles
		if (i_unlock) begin
			nxt_st.unlock_cnt = `SMC_UNLOCK_WINDOW;
		end else if (st_ff.unlock_cnt != 3'h0) begin
			nxt_st.unlock_cnt = st_ff.unlock_cnt - 3'h1;
		end

		// Register writes
		if (wr_live) begin
			case (idx)
				`SMC_IDX_DET_CTRL: begin
					// Sample rate and run mode ignore writes
					if (unlocked) begin
						nxt_st.sleep_mode = smc_mode_t'(
							wbyte[`SMC_POS_SLEEP_MODE +: 2]);
						nxt_st.unlock_cnt = 3'h0;
					end
				end
				`SMC_IDX_WARN_CTRL: begin
					nxt_st.offset = wbyte[`SMC_POS_OFFSET +: 2];
				end
				`SMC_IDX_WARN_IRQ_CTRL: begin
					nxt_st.direction = smc_dir_t'(
						wbyte[`SMC_POS_DIRECTION +: 2]);
					nxt_st.irq_en = wbyte[`SMC_POS_IRQ_ENABLE];
				end
				default: begin
					nxt_st.offset = st_ff.offset;
				end
			endcase
		end

		// Comparator evaluation
		if (evaluate) begin
			nxt_st.below      = below_sync;
			nxt_st.prev_below = below_sync;
			nxt_st.seen       = 1'b1;
		end else if (!enabled) begin
			nxt_st.seen = 1'b0;
		end
		// Entering or leaving deep sleep restarts the comparison history
		if (i_deep_sleep != sleep_ff) begin
			nxt_st.seen = 1'b0;
		end

		// Set wins over clear
		nxt_st.irq_flag = (st_ff.irq_flag & ~flag_clr) | flag_set;

		// Registered outputs
		nxt_st.irq         = nxt_st.irq_en & nxt_st.irq_flag;
		nxt_st.det_en      = enabled;
		nxt_st.det_sampled = sampled;
		nxt_st.exec_hold   = (st_ff.fsm == SMC_ST_RUN) & ~i_deep_sleep &
			(st_ff.run_mode == SMC_MODE_HOLD) & ~ready_sync;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff <= '{
				fsm:         SMC_ST_LOAD,
				sample_rate: 1'b0,
				run_mode:    SMC_MODE_DIS,
				sleep_mode:  SMC_MODE_DIS,
				level:       3'h0,
				offset:      `SMC_RST_OFFSET,
				direction:   SMC_DIR_BELOW,
				irq_en:      `SMC_RST_IRQ_ENABLE,
				irq_flag:    `SMC_RST_IRQ_FLAG,
				below:       `SMC_RST_BELOW_STATUS,
				prev_below:  1'b0,
				seen:        1'b0,
				unlock_cnt:  3'h0,
				ack:         1'b0,
				rdata:       8'h00,
				irq:         1'b0,
				det_en:      1'b0,
				det_sampled: 1'b0,
				exec_hold:   1'b0
			};
			tick_ff <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			tick_ff <= tick & sampled;
		end
	end

	// Sleep state of the previous cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sleep_ff <= 1'b0;
		end else begin
			sleep_ff <= i_deep_sleep;
		end
	end

	always_comb begin
		o_wb.ack        = st_ff.ack;
		o_wb.dat        = {24'h000000, st_ff.rdata};
		o_det_enable    = st_ff.det_en;
		o_det_sampled   = st_ff.det_sampled;
		o_sample_strobe = tick_ff;
		o_det_threshold = st_ff.level;
		o_warn_offset   = st_ff.offset;
		o_exec_hold     = st_ff.exec_hold;
		o_warn_irq      = st_ff.irq;
	end
endmodule : smc_top
`default_nettype wire

/* File: smc_top_bench.sv */
// Self-checking bench for the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
module smc_top_bench
	import smc_pkg::*;
;
	logic        clk  = 1'b0;
	logic        nrst = 1'b0;
	smc_wb_req_t wb   = '0;
	smc_wb_rsp_t rsp;
	smc_fuse_t   fuse = '0;
	logic        unl  = 1'b0;
	logic        dsl  = 1'b0;
	logic        blw  = 1'b0;
	logic        rdy  = 1'b0;
	logic        den, dsm, stb, hold, irq;
	logic [2:0]  thr;
	logic [1:0]  offs;
	logic [31:0] d;
	int          md;
	int          bad_count = 0;
	int          n_checks  = 0;
	int          seed      = 63269;
	int          m[int];
	logic [7:0]  ad[8] = '{8'h00, 8'h04, 8'h20, 8'h24, 8'h28, 8'h2c,
		8'h10, 8'h05};

	always #10 clk = ~clk;

	smc_top #(.P_CYC_FAST(8), .P_CYC_SLOW(16)) uut (
		.i_clk(clk), .i_nrst(nrst), .i_wb(wb), .o_wb(rsp), .i_fuse(fuse),
		.i_unlock(unl), .i_deep_sleep(dsl), .i_warn_below(blw),
		.i_det_ready(rdy), .o_det_enable(den), .o_det_sampled(dsm),
		.o_sample_strobe(stb), .o_det_threshold(thr),
		.o_warn_offset(offs), .o_exec_hold(hold), .o_warn_irq(irq)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// One classic cycle; reads compared with the model
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] v);
		@(posedge clk);
		wb <= '{1'b1, 1'b1, we, a, 4'h1, v};
		do @(posedge clk); while (rsp.ack !== 1'b1);
		if (!we) chk(rsp.dat, m.exists(a) ? m[a] : 0);
		wb.cyc <= 1'b0;
		wb.stb <= 1'b0;
	endtask : bus

	task automatic unlock();
		unl <= 1'b1;
		@(posedge clk);
		unl <= 1'b0;
	endtask : unlock

	task automatic rst();
		nrst <= 1'b0;
		tick(12);
		nrst <= 1'b1;
		m.delete();
		m[0] = {fuse.sample_rate, fuse.run_mode, fuse.sleep_mode};
		m[4] = fuse.level;
		tick(3);
	endtask : rst

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	initial begin
		tick(5000);
		bad_count++;
		stop_test();
	end

	initial begin
		fuse.level <= 3'($random(seed));
		for (int r = 0; r < 4; r++) begin
			md = (r + 2) % 4;
			fuse.run_mode <= 2'(md);
			fuse.sample_rate <= 1'(r % 2);
			rdy <= 1'b0;
			rst();
			chk(den, md != 0);
			chk(dsm, md == 2);
			chk(hold, md == 3);
			bus(1, 8'h00, 32'hff);
			bus(0, 8'h00, 0);
			chk(thr, fuse.level);
			rdy <= 1'b1;
			tick(8);
			chk(hold, 0);
		end
		foreach (ad[i]) bus(0, ad[i], 0);
		d = $random(seed);
		bus(1, 8'h20, d);
		m[32] = d[1:0];
		bus(0, 8'h20, 0);
		chk(offs, m[32]);
		for (int k = 0; k < 4; k++) begin
			m[36] = 2 * k + 1 - k % 2;
			bus(1, 8'h24, m[36]);
			bus(0, 8'h24, 0);
			bus(1, 8'h28, 1);
			m[40] = 0;
			blw <= 1'b1;
			tick(10);
			m[44] = 1;
			if (k % 2 == 0) m[40] = 1;
			chk(irq, m[40] & m[36] & 1);
			bus(0, 8'h2c, 0);
			blw <= 1'b0;
			tick(10);
			m[44] = 0;
			if (k == 1 || k == 2) m[40] = 1;
			chk(irq, m[40] & m[36] & 1);
			bus(1, 8'h28, 0);
			bus(0, 8'h28, 0);
			bus(1, 8'h28, 1);
			m[40] = 0;
			bus(0, 8'h28, 0);
			chk(irq, 0);
		end
		for (int s = 1; s < 5; s++) begin
			unlock();
			bus(1, 8'h00, s % 4);
			m[0] = (m[0] & 32'h1c) | s % 4;
			bus(0, 8'h00, 0);
			dsl <= 1'b1;
			tick(60);
			chk(den, s < 3);
			chk(dsm, s == 2);
			dsl <= 1'b0;
			tick(3);
			chk(den, 1);
		end
		bus(1, 8'h00, 32'h2);
		unlock();
		tick(5);
		bus(1, 8'h00, 32'h1);
		bus(0, 8'h00, 0);
		bus(1, 8'h24, 32'h5);
		m[36] = 5;
		dsl <= 1'b1;
		blw <= 1'b1;
		tick(10);
		bus(0, 8'h28, 0);
		bus(0, 8'h2c, 0);
		dsl <= 1'b0;
		tick(10);
		m[44] = 1;
		bus(0, 8'h2c, 0);
		bus(0, 8'h28, 0);
		stop_test();
	end
endmodule : smc_top_bench
`default_nettype wire

/* File: smc_top_chk.sv */
// Assertion checker for the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
module smc_top_chk
	import smc_pkg::*;
#(
	parameter int P_CYC_FAST = 8,
	parameter int P_CYC_SLOW = 16
) (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire smc_wb_req_t i_wb,
	input  wire smc_wb_rsp_t o_wb,
	input  wire smc_fuse_t   i_fuse,
	input  wire logic        i_deep_sleep,
	input  wire logic        o_det_enable,
	input  wire logic        o_det_sampled,
	input  wire logic        o_sample_strobe,
	input  wire logic [2:0]  o_det_threshold
);
	logic [7:0] gap_ff;
	logic       ok_ff;

	// Distance between sample strobes
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gap_ff <= 8'h0;
			ok_ff  <= 1'b0;
		end else begin
			gap_ff <= o_sample_strobe ? 8'h1 : gap_ff + 8'h1;
			ok_ff  <= o_det_sampled && (o_sample_strobe || ok_ff);
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	a_ack_pulse: assert property (o_wb.ack |=> !o_wb.ack)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (i_wb.cyc && i_wb.stb && !o_wb.ack
		|=> o_wb.ack)
		else $error("request not answered");
	a_level_fuse: assert property ($past(i_nrst, 3) |->
		o_det_threshold == i_fuse.level)
		else $error("threshold differs from fuse");
	a_level_read: assert property (
		o_wb.ack && !i_wb.we && i_wb.adr == 8'h04 |->
		o_wb.dat == {29'h0, i_fuse.level})
		else $error("level register wrong");
	a_ctrl_read: assert property (
		o_wb.ack && !i_wb.we && i_wb.adr == 8'h00 |->
		o_wb.dat[7:2] == {3'h0, i_fuse.sample_rate, i_fuse.run_mode})
		else $error("control register wrong");
	a_run_mode: assert property ($past(i_nrst, 3) &&
		!$past(i_deep_sleep) && !$past(i_deep_sleep, 2) |->
		o_det_enable == (i_fuse.run_mode != 2'h0) &&
		o_det_sampled == (i_fuse.run_mode == 2'h2))
		else $error("run mode not applied");
	a_strobe_samp: assert property (o_sample_strobe |->
		o_det_sampled || $past(o_det_sampled))
		else $error("strobe outside sampled mode");
	a_strobe_period: assert property (o_sample_strobe && ok_ff |->
		gap_ff == 8'(i_fuse.sample_rate ? P_CYC_SLOW : P_CYC_FAST))
		else $error("sample period wrong");
endmodule : smc_top_chk

bind smc_top smc_top_chk #(
	.P_CYC_FAST(P_CYC_FAST),
	.P_CYC_SLOW(P_CYC_SLOW)
) u_chk (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_wb(i_wb), .o_wb(o_wb),
	.i_fuse(i_fuse), .i_deep_sleep(i_deep_sleep),
	.o_det_enable(o_det_enable), .o_det_sampled(o_det_sampled),
	.o_sample_strobe(o_sample_strobe), .o_det_threshold(o_det_threshold)
);
`default_nettype wire
